// *** ipi_cfg.svh ***
`ifndef IPI_CFG_SVH
`define IPI_CFG_SVH
// register byte addresses (apb word aligned)
`define IPI_OFS_SWITCH 12'h000
`define IPI_OFS_AN0 12'h004
`define IPI_OFS_AN1 12'h008
`define IPI_OFS_PINSENSE 12'h00c
`define IPI_OFS_PINROLE 12'h010
`define IPI_OFS_PINOUT 12'h014
`define IPI_OFS_RETCTRL 12'h018
`define IPI_OFS_TEMP0 12'h020
`define IPI_OFS_BK_TO_DEV 12'h040
`define IPI_OFS_BK_TO_HOST 12'h060
// field layout
`define IPI_AN_BITS 10
`define IPI_AN_MAX 10'h3ff
`define IPI_AVG_COUNT 4'ha
`define IPI_BACKUP_BYTES 32
`define IPI_ROLE_RESET 8'h00
`define IPI_RETCTRL_EN_BIT 0
`define IPI_RETCTRL_FINE_BIT 1
`endif

// *** ipi_pkg.sv ***
package ipi_pkg;
   typedef enum logic [1:0] {IPI_ROLE_IN = 2'b00, IPI_ROLE_OUT = 2'b01, IPI_ROLE_SENSOR = 2'b11} ipi_role_t;
   typedef enum logic [1:0] {IPI_AV_IDLE = 2'b00, IPI_AV_SUM = 2'b01, IPI_AV_DIV = 2'b11} ipi_avg_state_t;
endpackage

// *** ipi_avg_if.sv ***
`timescale 1ns/10ps
interface ipi_avg_if;
   logic sample_valid;
   logic [9:0] sample;
   logic result_valid;
   logic [9:0] result;
   modport avg (input sample_valid, input sample, output result_valid, output result);
   modport user (output sample_valid, output sample, input result_valid, input result);
endinterface

// *** ipi_averager.sv ***
`timescale 1ns/10ps
`include "ipi_cfg.svh"
module ipi_averager (
   input wire logic pclk,
   input wire logic presetn,
   ipi_avg_if.avg port_a
);
   logic [13:0] sum_ff;
   logic [3:0] cnt_ff;
   logic [13:0] quot_ff;
   logic [13:0] rem_ff;
   ipi_pkg::ipi_avg_state_t st_ff;
   logic [9:0] res_ff;
   logic rv_ff;

   // accumulate ten conversions, then divide by repeated subtraction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sum_ff <= 14'h0000;
         cnt_ff <= 4'h0;
         quot_ff <= 14'h0000;
         rem_ff <= 14'h0000;
         st_ff <= ipi_pkg::IPI_AV_IDLE;
         res_ff <= 10'h000;
         rv_ff <= 1'b0;
      end
      else
      begin
         rv_ff <= 1'b0;
         unique case (st_ff)
            ipi_pkg::IPI_AV_IDLE, ipi_pkg::IPI_AV_SUM:
            begin
               if (port_a.sample_valid)
               begin
                  sum_ff <= sum_ff + {4'h0, port_a.sample};
                  cnt_ff <= cnt_ff + 4'h1;
                  st_ff <= ipi_pkg::IPI_AV_SUM;
                  if (cnt_ff == `IPI_AVG_COUNT - 4'h1)
                  begin
                     rem_ff <= sum_ff + {4'h0, port_a.sample};
                     quot_ff <= 14'h0000;
                     st_ff <= ipi_pkg::IPI_AV_DIV;
                  end
               end
            end
            ipi_pkg::IPI_AV_DIV:
            begin
               // slow divide, at most 1023 steps, far below any sample rate
               if (rem_ff >= 14'd10)
               begin
                  rem_ff <= rem_ff - 14'd10;
                  quot_ff <= quot_ff + 14'h0001;
               end
               else
               begin
                  // mean of 10-bit values never exceeds 1023; clamp anyway
                  res_ff <= (quot_ff > 14'h03ff) ? `IPI_AN_MAX : quot_ff[9:0];
                  rv_ff <= 1'b1;
                  sum_ff <= 14'h0000;
                  cnt_ff <= 4'h0;
                  st_ff <= ipi_pkg::IPI_AV_IDLE;
               end
            end
            default:
               st_ff <= ipi_pkg::IPI_AV_IDLE;
         endcase
      end
   end

   assign port_a.result = res_ff;
   assign port_a.result_valid = rv_ff;
endmodule // ipi_averager

// *** ipi_process_image.sv ***
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "ipi_cfg.svh"
// Contract
// [R1] backup area is 32 bytes each way, format free
// [R2] bytes to device are accepted on every exchange, retention or not
// [R3] with retention on, last bytes survive supply loss, returned after start-up
// [R4] eight switch inputs packed in one byte, input zero at bit 0
// [R5] switch bit is 0 when idle, 1 with voltage applied
// [R6] analog 10-bit result in 16-bit word, top two bits in high byte 1..0
// [R7] analog result is the mean of ten successive conversions
// [R8] analog results lie within 0..1023
// [R9] pin state byte: four pins in bits 3..0, bits 7..4 unassigned
// [R10] all four pins are inputs after reset
// [R11] each pin selectable as input, output or sensor via its role byte; code packs two role bits per pin into one byte at the role register
// [R12] sensor mode: per-pin 16-bit temperature word, pins zero to three
// [R13] coarse sensor: whole degrees times 256, no fraction
// [R14] fine sensor: tenths of a degree
// [R15] fine sensor: negative flagged by msb of high byte
// [R16] input and temperature bytes read zero until first valid data
// [R17] unassigned analog high and pin byte bits read zero
module ipi_process_image #(
   parameter int NUM_PINS = 4,
   parameter int NUM_AN = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] switch_in,
   input wire logic [NUM_AN-1:0] an_sample_valid,
   input wire logic [NUM_AN*10-1:0] an_sample,
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n,
   input wire logic [NUM_PINS-1:0] sensor_valid,
   input wire logic [NUM_PINS-1:0] sensor_fine,
   input wire logic [NUM_PINS-1:0] sensor_neg,
   input wire logic [NUM_PINS*16-1:0] sensor_raw,
   input wire logic supply_fail,
   output logic retain_save,
   output logic [255:0] retain_save_data,
   input wire logic retain_restore_valid,
   input wire logic [255:0] retain_restore_data
);
   logic [7:0] switch_ff;
   logic [9:0] an_ff [NUM_AN];
   logic [7:0] role_ff [NUM_PINS];
   logic [NUM_PINS-1:0] pin_out_ff;
   logic [NUM_PINS-1:0] pin_sense_ff;
   logic [15:0] temp_ff [NUM_PINS];
   logic [7:0] bk_dev_ff [`IPI_BACKUP_BYTES];
   logic [7:0] bk_host_ff [`IPI_BACKUP_BYTES];
   logic ret_en_ff;
   logic save_ff;
   logic fail_d_ff;
   logic [31:0] nxt_rdata;
   logic nxt_err;
   logic wr_acc;
   logic rd_acc;

   ////////////////////////////////////////////////////////////////
   // apb: zero wait states, every access completes in one access cycle
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   ////////////////////////////////////////////////////////////////
   // switch inputs sampled straight; idle low, driven high
   // [R4] [R5] switch byte packing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         switch_ff <= 8'h00;
      else
         switch_ff <= switch_in;
   end

   ////////////////////////////////////////////////////////////////
   // analog averaging, one averager per channel
   genvar gi;
   generate
      for (gi = 0; gi < NUM_AN; gi++)
      begin : g_an
         ipi_avg_if av ();
         assign av.sample_valid = an_sample_valid[gi];
         assign av.sample = an_sample[gi*10 +: 10];
         // [R7] ten-sample mean
         ipi_averager u_avg (
            .pclk(pclk),
            .presetn(presetn),
            .port_a(av.avg)
         );
         // [R16] zero until first mean
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               an_ff[gi] <= 10'h000;
            else if (av.result_valid)
               an_ff[gi] <= av.result;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // pin roles; outputs driven only in output role
   // [R10] reset to input
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_PINS; i++)
            role_ff[i] <= `IPI_ROLE_RESET;
         pin_out_ff <= '0;
      end
      else if (wr_acc && pstrb[0])
      begin
         for (int i = 0; i < NUM_PINS; i++)
            if (paddr == `IPI_OFS_PINROLE)
               role_ff[i] <= {6'h00, pwdata[i*2 +: 2]};
         if (paddr == `IPI_OFS_PINOUT)
            pin_out_ff <= pwdata[NUM_PINS-1:0];
      end
   end

   // [R11] role decode
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         pin_oe_n[i] = !(role_ff[i][1:0] == ipi_pkg::IPI_ROLE_OUT);
         pin_out[i] = pin_out_ff[i];
      end
   end

   // pin sense; pins in sensor role report zero since the line belongs to the sensor
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_sense_ff <= '0;
      else
         for (int i = 0; i < NUM_PINS; i++)
            pin_sense_ff[i] <= (role_ff[i][1:0] == ipi_pkg::IPI_ROLE_SENSOR) ? 1'b0 : pin_in[i];
   end

   ////////////////////////////////////////////////////////////////
   // temperature words, formatted per sensor type
   // [R12] per-pin word update
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // [R16] zero until first reading
         for (int i = 0; i < NUM_PINS; i++)
            temp_ff[i] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < NUM_PINS; i++)
            if (sensor_valid[i] && role_ff[i][1:0] == ipi_pkg::IPI_ROLE_SENSOR)
            begin
               if (sensor_fine[i])
                  // [R14] [R15] tenths, sign in msb
                  temp_ff[i] <= {sensor_neg[i], sensor_raw[i*16 +: 15]};
               else
                  // [R13] whole degrees in high byte
                  temp_ff[i] <= {sensor_raw[i*16 +: 8], 8'h00};
            end
      end
   end

   ////////////////////////////////////////////////////////////////
   // backup bytes: host writes freely, save fires on supply loss while retention is enabled
   // [R1] [R2] outbound area always writable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < `IPI_BACKUP_BYTES; i++)
            bk_dev_ff[i] <= 8'h00;
         ret_en_ff <= 1'b0;
      end
      else if (wr_acc)
      begin
         for (int i = 0; i < `IPI_BACKUP_BYTES; i++)
            if (paddr == `IPI_OFS_BK_TO_DEV + 12'(4 * (i / 4)) && pstrb[i % 4])
               bk_dev_ff[i] <= pwdata[(i % 4) * 8 +: 8];
         if (paddr == `IPI_OFS_RETCTRL && pstrb[0])
            ret_en_ff <= pwdata[`IPI_RETCTRL_EN_BIT];
      end
   end

   // [R3] save on supply-fail rising edge, restore at start-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fail_d_ff <= 1'b0;
         save_ff <= 1'b0;
      end
      else
      begin
         fail_d_ff <= supply_fail;
         save_ff <= supply_fail && !fail_d_ff && ret_en_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         for (int i = 0; i < `IPI_BACKUP_BYTES; i++)
            bk_host_ff[i] <= 8'h00;
      else if (retain_restore_valid)
         for (int i = 0; i < `IPI_BACKUP_BYTES; i++)
            bk_host_ff[i] <= retain_restore_data[i*8 +: 8];
   end

   assign retain_save = save_ff;
   always_comb
   begin
      for (int i = 0; i < `IPI_BACKUP_BYTES; i++)
         retain_save_data[i*8 +: 8] = bk_dev_ff[i];
   end

   ////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses answer pslverr
   // [R6] [R8] [R9] [R17] packing with zero fill
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = 1'b0;
      if (paddr == `IPI_OFS_SWITCH)
         nxt_rdata = {24'h00_0000, switch_ff};
      else if (paddr == `IPI_OFS_AN0)
         nxt_rdata = {22'h00_0000, an_ff[0]};
      else if (paddr == `IPI_OFS_AN1)
         nxt_rdata = {22'h00_0000, an_ff[NUM_AN-1]};
      else if (paddr == `IPI_OFS_PINSENSE)
         nxt_rdata = {{(32-NUM_PINS){1'b0}}, pin_sense_ff};
      else if (paddr == `IPI_OFS_PINROLE)
      begin
         for (int i = 0; i < NUM_PINS; i++)
            nxt_rdata[i*2 +: 2] = role_ff[i][1:0];
      end
      else if (paddr == `IPI_OFS_PINOUT)
         nxt_rdata = {{(32-NUM_PINS){1'b0}}, pin_out_ff};
      else if (paddr == `IPI_OFS_RETCTRL)
         nxt_rdata = {31'h0000_0000, ret_en_ff};
      else if (paddr >= `IPI_OFS_TEMP0 && paddr < `IPI_OFS_TEMP0 + 12'(4 * NUM_PINS))
         nxt_rdata = {16'h0000, temp_ff[paddr[3:2]]};
      else if (paddr >= `IPI_OFS_BK_TO_DEV && paddr < `IPI_OFS_BK_TO_DEV + 12'h020)
         nxt_rdata = {bk_dev_ff[{paddr[4:2], 2'd3}], bk_dev_ff[{paddr[4:2], 2'd2}],
                      bk_dev_ff[{paddr[4:2], 2'd1}], bk_dev_ff[{paddr[4:2], 2'd0}]};
      else if (paddr >= `IPI_OFS_BK_TO_HOST && paddr < `IPI_OFS_BK_TO_HOST + 12'h020)
         nxt_rdata = {bk_host_ff[{paddr[4:2], 2'd3}], bk_host_ff[{paddr[4:2], 2'd2}],
                      bk_host_ff[{paddr[4:2], 2'd1}], bk_host_ff[{paddr[4:2], 2'd0}]};
      else
         nxt_err = 1'b1;
   end

   // read data only meaningful in the access phase
   assign prdata = rd_acc ? nxt_rdata : 32'h0000_0000;
   assign pslverr = psel && penable && nxt_err;
endmodule // ipi_process_image

// *** ipi_process_image_properties.sv ***
`timescale 1ns/10ps
module ipi_process_image_properties #(
   parameter int NUM_PINS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_PINS-1:0] pin_oe_n,
   input wire logic supply_fail,
   input wire logic retain_save
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic [NUM_PINS-1:0] exp_oe_n;
   assign acc = psel && penable;
   // only role 01 drives a pin; 10 and 11 leave it undriven
   always_comb
   begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         exp_oe_n[i] = !(pwdata[2*i+1 -: 2] == 2'b01);
      end
   end
   //////////////////////////////////////////////////////////////////
   property p_sw_hi;
      acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0;
   endproperty
   a_sw_hi: assert property (p_sw_hi) else $error("switch word upper bits set");
   property p_an_hi;
      acc && !pwrite && (paddr == 12'h004 || paddr == 12'h008) |-> prdata[31:10] == 22'h0;
   endproperty
   a_an_hi: assert property (p_an_hi) else $error("analog word above 10 bits");
   property p_pin_hi;
      acc && !pwrite && paddr == 12'h00c |-> prdata[31:4] == 28'h0;
   endproperty
   a_pin_hi: assert property (p_pin_hi) else $error("pin byte bits 7..4 set");
   property p_rst_in;
      $rose(presetn) |-> &pin_oe_n;
   endproperty
   a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
   property p_role;
      acc && pwrite && paddr == 12'h010 && pstrb[0] |=> pin_oe_n == $past(exp_oe_n);
   endproperty
   a_role: assert property (p_role) else $error("pin drive not per role");
   property p_save_one;
      retain_save |=> !retain_save;
   endproperty
   a_save_one: assert property (p_save_one) else $error("save pulse too long");
   property p_save_cause;
      retain_save |-> $past(supply_fail);
   endproperty
   a_save_cause: assert property (p_save_cause) else $error("save without supply loss");
   property p_unmap;
      acc && paddr == 12'h080 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("no error past backup area");
   property p_bk_ok;
      acc && paddr >= 12'h040 && paddr <= 12'h07c |-> !pslverr && pready;
   endproperty
   a_bk_ok: assert property (p_bk_ok) else $error("backup word refused");
   c_role: cover property (acc && pwrite && paddr == 12'h010);
   c_save: cover property (retain_save);
   c_unmap: cover property (acc && pslverr);
endmodule // ipi_process_image_properties

// *** ipi_backup_store.sv ***
`timescale 1ns/10ps
module ipi_backup_store (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic save,
   input wire logic [255:0] save_data,
   output logic restore_valid,
   output logic [255:0] restore_data
);
   logic [255:0] store_ff = '0;
   logic have_ff = 1'b0;
   logic up_ff;
   // keep bytes; not cleared by reset, like a nonvolatile cell
   always_ff @(posedge pclk)
   begin
      if (save)
      begin
         store_ff <= save_data;
         have_ff <= 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         up_ff <= 1'b0;
         restore_valid <= 1'b0;
      end
      else
      begin
         up_ff <= 1'b1;
         restore_valid <= !up_ff && have_ff;
      end
   end
   // idle lines inverted so stale data never looks valid
   assign restore_data = restore_valid ? store_ff : ~store_ff;
endmodule // ipi_backup_store

// *** ipi_process_image_test.sv ***
`timescale 1ns/10ps
module ipi_process_image_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_fail, retain_save, rst_v, err, seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, pin_in, pin_out, pin_oe_n, s_valid, s_fine, s_neg;
   logic [7:0] switch_in;
   logic [1:0] an_v;
   logic [19:0] an_s;
   logic [63:0] s_raw;
   logic [255:0] sv_data, rs_data, pat;
   int failures, checks_done;
   ipi_process_image #(.NUM_PINS(4), .NUM_AN(2)) ipi_process_image_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .switch_in, .an_sample_valid(an_v),
      .an_sample(an_s), .pin_in, .pin_out, .pin_oe_n, .sensor_valid(s_valid), .sensor_fine(s_fine),
      .sensor_neg(s_neg), .sensor_raw(s_raw), .supply_fail, .retain_save, .retain_save_data(sv_data),
      .retain_restore_valid(rst_v), .retain_restore_data(rs_data));
   ipi_backup_store ipi_backup_store_inst (.pclk, .presetn, .save(retain_save), .save_data(sv_data),
      .restore_valid(rst_v), .restore_data(rs_data));
   //////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic fail_pulse;
      supply_fail <= 1'b1;
      seen = 1'b0;
      // registered pulse still stands at the edge after it rises
      repeat (5)
      begin
         @(posedge pclk);
         if (retain_save === 1'b1) seen = 1'b1;
      end
      supply_fail <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   // free-running clock, 4 ns period
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // hang guard, far beyond the expected run
   initial
   begin
      #100000;
      failures++;
      complete_run;
   end
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, supply_fail} = '0;
      {paddr, pwdata, switch_in, an_v, an_s, pin_in, s_valid, s_fine, s_neg, s_raw} = '0;
      pstrb = 4'hf;
      failures = 0;
      checks_done = 0;
      for (int k = 0; k < 8; k++) pat[32*k +: 32] = 32'hc3a5_0f10 + k;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 7; k++)
      begin
         xfer(1'b0, (k < 3) ? 12'(4 * k) : 12'(12'h020 + 4 * (k - 3)), 32'h0);
         chk("start value", rd, 32'h0);
      end
      xfer(1'b0, 12'h080, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      for (int k = 0; k < 2; k++)
      begin
         switch_in <= k ? 8'h7e : 8'h81;
         xfer(1'b1, 12'h000, 32'hffff_ffff);
         repeat (3) @(posedge pclk);
         xfer(1'b0, 12'h000, 32'h0);
         chk("switch", rd, k ? 32'h7e : 32'h81);
      end
      for (int k = 0; k < 10; k++)
      begin
         an_s <= {10'h3ff, 10'(2 * k)};
         an_v <= 2'b11;
         @(posedge pclk);
         an_v <= 2'b00;
         @(posedge pclk);
      end
      repeat (1100) @(posedge pclk);
      xfer(1'b0, 12'h004, 32'h0);
      chk("analog mean", rd, 32'h9);
      xfer(1'b0, 12'h008, 32'h0);
      chk("analog top", rd, 32'h3ff);
      xfer(1'b1, 12'h010, 32'hc4);
      xfer(1'b1, 12'h014, 32'h2);
      pin_in <= 4'hf;
      repeat (3) @(posedge pclk);
      chk("pin drive", {28'h0, pin_oe_n}, 32'hd);
      chk("pin out", {31'h0, pin_out[1]}, 32'h1);
      xfer(1'b0, 12'h00c, 32'h0);
      chk("pin sense", rd & 32'hffff_fffd, 32'h5);
      for (int k = 0; k < 2; k++)
      begin
         s_fine <= k ? 4'h0 : 4'h8;
         s_neg <= k ? 4'h0 : 4'h8;
         s_raw <= {k ? 16'h0016 : 16'h00e0, 32'h0, 16'h0016};
         s_valid <= 4'h9;
         @(posedge pclk);
         s_valid <= 4'h0;
         repeat (3) @(posedge pclk);
         xfer(1'b0, 12'h02c, 32'h0);
         chk("temp", rd, k ? 32'h1600 : 32'h80e0);
         xfer(1'b0, 12'h020, 32'h0);
         chk("temp in-role", rd, 32'h0);
      end
      for (int k = 0; k < 8; k++) xfer(1'b1, 12'(12'h040 + 4 * k), pat[32*k +: 32]);
      for (int k = 0; k < 8; k++)
      begin
         xfer(1'b0, 12'(12'h040 + 4 * k), 32'h0);
         chk("to device", rd, pat[32*k +: 32]);
      end
      fail_pulse;
      chk("save off", {31'h0, seen}, 32'h0);
      xfer(1'b1, 12'h018, 32'h1);
      fail_pulse;
      chk("save on", {31'h0, seen}, 32'h1);
      for (int k = 0; k < 8; k++) chk("saved", sv_data[32*k +: 32], pat[32*k +: 32]);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      for (int k = 0; k < 8; k++)
      begin
         xfer(1'b0, 12'(12'h060 + 4 * k), 32'h0);
         chk("to host", rd, pat[32*k +: 32]);
      end
      complete_run;
   end
endmodule // ipi_process_image_test
bind ipi_process_image ipi_process_image_properties #(.NUM_PINS(NUM_PINS)) ipi_process_image_properties_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .pin_oe_n, .supply_fail, .retain_save);
